// ==== src/dsd_top.sv ====
// drive-side serial write/read data path and drive fault latch
// assumes controller pins are asynchronous; write clock is echoed back
// How it works
// - fault on gate/write-current mismatch
// - fault on write gate without ready or with write lock
// - fault on multiple heads or no flux
// - fault on spindle error, or off track while track following and ready
// - fault on reset while up, restore failure
// - fault on watchdog expiry
// - write bit taken on echo clock falling edge
// - recovered clock switched in after 6 us
// - servo clock drives reference while gate idle
// - controller gates act only when unit selected
// - reset keeps sequencing, restores when up
// - fault on write between index and sector
`timescale 1ns/10ps
module dsd_top
	import dsd_pkg::*;
#(
	parameter int WD_CYCLES = WD_CYC
) (
	input  wire logic                mclk,
	input  wire logic                rst,
	input  wire dsd_pkg::dsd_gates_t gatesIn,
	input  wire dsd_pkg::dsd_health_t health,
	input  wire logic                servoClk,
	input  wire logic                dataClk,
	input  wire logic                readBitIn,
	input  wire logic                echoClk,
	input  wire logic                writeBitIn,
	input  wire logic                watchdogKick,
	output logic                     refClk,
	output logic                     readBitOut,
	output logic                     readValid,
	output logic                     encBit,
	output logic                     encStrobe,
	output logic                     writeEnable,
	output logic                     restoreReq,
	output logic                     driveFault
);
	import dsd_pkg::*;

	// refuse a watchdog limit too small to ever count a cycle
	if (WD_CYCLES < 2) begin
		$error("watchdog count too small");
	end

	// every pin but watchdogKick, and the health bus, are foreign to mclk
	localparam int NS = 4 + 11 + 5;
	logic [NS-1:0] syncIn;
	logic [NS-1:0] syncOut;
	assign syncIn = {gatesIn, health, servoClk, dataClk, readBitIn, echoClk, writeBitIn};

	dsd_sync #(.W(NS)) uSync (
		.mclk (mclk),
		.rst  (rst),
		.din  (syncIn),
		.dout (syncOut)
	);

	dsd_gates_t  g;
	dsd_health_t h;
	logic        sServo, sData, sRead, sEcho, sWbit;
	assign {g, h, sServo, sData, sRead, sEcho, sWbit} = syncOut;

	// gated by selection so an unselected drive ignores the cable
	logic selWrite, selRead, selReset;
	assign selWrite = g.select & g.writeGate;
	assign selRead  = g.select & g.readGate;
	assign selReset = g.select & g.reset;

	// ---- read clock source selection
	dsd_src_t     src_reg, src_next;
	logic [8:0]   syncCnt_reg, syncCnt_next;
	always_comb begin
		src_next     = src_reg;
		syncCnt_next = syncCnt_reg;
		unique case (src_reg)
			SRC_SERVO: begin
				syncCnt_next = '0;
				if (selRead)
					src_next = SRC_WAIT;
			end
			SRC_WAIT: begin
				if (!selRead)
					src_next = SRC_SERVO;
				else if (syncCnt_reg == 9'(SYNC_SWAP_CYC - 1))
					src_next = SRC_DATA;
				syncCnt_next = syncCnt_reg + 9'h001;
			end
			SRC_DATA: begin
				if (!selRead)
					src_next = SRC_SERVO;
				else if (syncCnt_reg != 9'(SYNC_INV_CYC))
					syncCnt_next = syncCnt_reg + 9'h001;
			end
			default: src_next = SRC_SERVO;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			src_reg     <= SRC_SERVO;
			syncCnt_reg <= '0;
		end else begin
			src_reg     <= src_next;
			syncCnt_reg <= syncCnt_next;
		end
	end

	// ---- reference clock and read bit outputs, registered
	logic refClk_next, readBitOut_next, readValid_next;
	always_comb begin
		refClk_next     = (src_reg == SRC_DATA) ? sData : sServo;
		readBitOut_next = (src_reg == SRC_DATA) ? sRead : 1'b0;
		// gives the controller a marker for the settle window
		// drops with the gate so a deselect cannot leave it up a cycle
		readValid_next  = (src_reg == SRC_DATA) && selRead && (syncCnt_reg == 9'(SYNC_INV_CYC));
	end

	// ---- write bit capture on echo falling edge
	logic echoD_reg, encBit_next, encStrobe_next;
	logic wbitPrev_reg, fluxSeen;
	always_comb begin
		encStrobe_next = echoD_reg & ~sEcho & selWrite;
		encBit_next    = encStrobe_next ? sWbit : encBit;
		fluxSeen       = encStrobe_next & (sWbit != wbitPrev_reg);
	end

	// ---- no-flux counter during writes
	logic [6:0] noFlux_reg, noFlux_next;
	always_comb begin
		noFlux_next = noFlux_reg;
		if (!selWrite || fluxSeen)
			noFlux_next = '0;
		else if (encStrobe_next && noFlux_reg != 7'(NOFLUX_CYC))
			noFlux_next = noFlux_reg + 7'h01;
	end

	// ---- index window: from index until first sector mark
	logic idxWin_reg, idxWin_next, idxPrev_reg;
	always_comb begin
		idxWin_next = idxWin_reg;
		if (h.sectorMark)
			idxWin_next = 1'b0;
		else if (h.index && !idxPrev_reg)
			idxWin_next = 1'b1;
	end

	// ---- watchdog, reloaded by the internal firmware kick
	logic [31:0] wd_reg, wd_next;
	logic        kickSeen;
	assign kickSeen = watchdogKick; // same-domain input
	always_comb begin
		if (kickSeen)
			wd_next = '0;
		else if (wd_reg != 32'(WD_CYCLES))
			wd_next = wd_reg + 32'h00000001;
		else
			wd_next = wd_reg;
	end

	// ---- reset edge and restore request
	logic resetPrev_reg, resetRise, restoreReq_next;
	assign resetRise = selReset & ~resetPrev_reg;
	always_comb begin
		restoreReq_next = resetRise & h.sequencedUp;
	end

	// ---- fault causes; latched until a reset while sequenced down
	logic faultSet, faultClear, driveFault_next;
	always_comb begin
		faultSet = 1'b0;
		faultSet |= (selWrite & ~h.writeCurrent) | (~selWrite & h.writeCurrent);
		faultSet |= selWrite & (~h.ready | h.writeLock);
		faultSet |= h.multiHead | (noFlux_reg == 7'(NOFLUX_CYC));
		faultSet |= h.spindleErr | (h.offTrack & h.trackFollow & h.ready);
		faultSet |= (resetRise & h.sequencedUp) | h.restoreFail;
		faultSet |= (wd_reg == 32'(WD_CYCLES));
		faultSet |= selWrite & idxWin_reg;
		faultClear      = resetRise & ~h.sequencedUp;
		// a new cause in the clearing cycle keeps the fault
		driveFault_next = faultSet | (driveFault & ~faultClear);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			refClk        <= 1'b0;
			readBitOut    <= 1'b0;
			readValid     <= 1'b0;
			echoD_reg     <= 1'b0;
			encBit        <= 1'b0;
			encStrobe     <= 1'b0;
			wbitPrev_reg  <= 1'b0;
			noFlux_reg    <= '0;
			idxWin_reg    <= 1'b0;
			idxPrev_reg   <= 1'b0;
			wd_reg        <= '0;
			resetPrev_reg <= 1'b0;
			restoreReq    <= 1'b0;
			driveFault    <= 1'b0;
			writeEnable   <= 1'b0;
		end else begin
			refClk        <= refClk_next;
			readBitOut    <= readBitOut_next;
			readValid     <= readValid_next;
			echoD_reg     <= sEcho;
			encBit        <= encBit_next;
			encStrobe     <= encStrobe_next;
			wbitPrev_reg  <= encStrobe_next ? sWbit : wbitPrev_reg;
			noFlux_reg    <= noFlux_next;
			idxWin_reg    <= idxWin_next;
			idxPrev_reg   <= h.index;
			wd_reg        <= wd_next;
			resetPrev_reg <= selReset;
			restoreReq    <= restoreReq_next;
			driveFault    <= driveFault_next;
			writeEnable   <= selWrite & ~driveFault; // write current only while healthy
		end
	end
endmodule

// ==== src/dsd_pkg.sv ====
// package for the drive-side serial data and fault block
// shared by dsd_top, dsd_top_asserts and test_dsd_top; no surroundings assumed
package dsd_pkg;
	localparam int CLK_MHZ       = 40;
	localparam int SYNC_SWAP_US  = 6;                      // recovered clock takes over the reference line
	localparam int SYNC_SWAP_CYC = SYNC_SWAP_US * CLK_MHZ; // 240 cycles
	localparam int SYNC_INV_US   = 9;                      // read bits unreliable this long
	localparam int SYNC_INV_CYC  = SYNC_INV_US * CLK_MHZ;  // 360 cycles
	localparam int WD_CYC        = 4000000;                // watchdog default, 100 ms at 40 MHz
	localparam int NOFLUX_CYC    = 80;                     // write strobes without a bit change
	localparam logic [2:0] SRC_RESET = 3'h0;

	// asynchronous inputs from the controller
	typedef struct packed {
		logic select;
		logic reset;
		logic writeGate;
		logic readGate;
	} dsd_gates_t;

	// drive-internal health inputs
	typedef struct packed {
		logic writeCurrent;
		logic writeLock;
		logic ready;
		logic multiHead;
		logic spindleErr;
		logic offTrack;
		logic trackFollow;
		logic restoreFail;
		logic sequencedUp;
		logic index;
		logic sectorMark;
	} dsd_health_t;

	// clock source for the reference output
	typedef enum logic [2:0] {
		SRC_SERVO = 3'b001,
		SRC_WAIT  = 3'b010,
		SRC_DATA  = 3'b100
	} dsd_src_t;
endpackage

// ==== src/dsd_sync.sv ====
// two-flop synchroniser, one per bit
// assumes din comes from outside the mclk domain
`timescale 1ns/10ps
module dsd_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] dout_next;

	// first stage only feeds the second
	always_comb begin
		meta_next = din;
		dout_next = meta_reg;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			dout     <= '0;
		end else begin
			meta_reg <= meta_next;
			dout     <= dout_next;
		end
	end
endmodule

// ==== tb/dsd_top_asserts.sv ====
// checker on the ports of dsd_top
// bound into every dsd_top; all of it lives in the mclk domain
`timescale 1ns/10ps
module dsd_top_asserts
	import dsd_pkg::*;
#(
	parameter int WD_CYCLES = WD_CYC
) (
	input wire logic                 mclk,
	input wire logic                 rst,
	input wire dsd_pkg::dsd_gates_t  gatesIn,
	input wire dsd_pkg::dsd_health_t health,
	input wire logic                 servoClk,
	input wire logic                 dataClk,
	input wire logic                 refClk,
	input wire logic                 readValid,
	input wire logic                 writeEnable,
	input wire logic                 encStrobe,
	input wire logic                 restoreReq,
	input wire logic                 driveFault
);
	int gateReg;
	int gateNext;
	// age of the selected read gate, saturating so it never wraps
	always_comb begin
		gateNext = 0;
		if (gatesIn.select && gatesIn.readGate)
			gateNext = (gateReg < 1000) ? gateReg + 1 : gateReg;
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			gateReg <= 0;
		else
			gateReg <= gateNext;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	chk_write_mismatch: assert property ((gatesIn.select && (gatesIn.writeGate ^ health.writeCurrent))[*4] |-> driveFault)
		else $error("gate and current disagree without fault");
	chk_head_spindle: assert property ((health.multiHead || health.spindleErr)[*4] |-> driveFault)
		else $error("head or spindle error without fault");
	chk_fault_clear: assert property ($fell(driveFault) |-> $past(gatesIn.reset, 2) && !health.sequencedUp)
		else $error("fault dropped without reset while down");
	chk_unselected_idle: assert property ((!gatesIn.select)[*4] |-> !encStrobe && !writeEnable && !readValid)
		else $error("activity while not selected");
	chk_servo_source: assert property ((!gatesIn.readGate)[*5] |-> refClk == $past(servoClk, 3))
		else $error("reference not from servo clock");
	chk_data_source: assert property (gateReg > SYNC_SWAP_CYC + 6 |-> refClk == $past(dataClk, 3))
		else $error("reference not from data clock");
	chk_valid_late: assert property (gateReg > SYNC_INV_CYC + 8 |-> readValid)
		else $error("read valid missing");
	chk_restore_up: assert property (restoreReq |-> health.sequencedUp && $past(gatesIn.reset, 3))
		else $error("restore without reset while up");
endmodule

bind dsd_top dsd_top_asserts #(.WD_CYCLES(WD_CYCLES)) u_chk (.*);

// ==== tb/dsd_ctrl_model.sv ====
// controller stand-in: echoes the reference clock, sends NRZ write bits
// assumes refClk from dsd_top; pat is set by the bench
`timescale 1ns/10ps
module dsd_ctrl_model (
	input  wire logic       refClk,
	input  wire logic [7:0] pat,
	output logic            echoClk,
	output logic            writeBit,
	output logic            heldBit
);
	int idx = 0;
	initial echoClk = 1'b0;
	initial writeBit = 1'b0;
	initial heldBit = 1'b0;
	// cable-like delay, so the bit is settled at the falling echo edge
	always @(refClk) echoClk <= #30 refClk;
	// launch on the rising reference edge
	always @(posedge refClk) begin
		writeBit <= pat[idx[2:0]];
		idx <= idx + 1;
	end
	// what the drive should capture at the falling echo edge
	always @(negedge echoClk) heldBit = writeBit;
endmodule

// ==== tb/test_dsd_top.sv ====
// bench for dsd_top: fault table, then reset, write and read cases
// controller side comes from dsd_ctrl_model
`timescale 1ns/10ps
module test_dsd_top;
	import dsd_pkg::*;
	typedef struct {dsd_gates_t g; dsd_health_t h; logic f;} dsd_case_t;
	// gates: 8 select, a +write, 9 +read, c +reset
	dsd_case_t rows[11] = '{'{4'ha, 11'h100, 1'b1}, '{4'h8, 11'h500, 1'b1}, '{4'ha, 11'h400, 1'b1},
		'{4'ha, 11'h700, 1'b1}, '{4'h8, 11'h080, 1'b1}, '{4'h8, 11'h040, 1'b1}, '{4'h8, 11'h130, 1'b1},
		'{4'h8, 11'h030, 1'b0}, '{4'h8, 11'h008, 1'b1}, '{4'ha, 11'h500, 1'b0}, '{4'ha, 11'h502, 1'b1}};
	logic mclk = 0, rst = 1, servoClk = 0, dataClk = 0, readBitIn = 0, watchdogKick = 0, kickOn = 1;
	logic echoClk, writeBitIn, heldBit, refClk, readBitOut, readValid, encBit, encStrobe, writeEnable;
	logic restoreReq, driveFault;
	dsd_gates_t gatesIn = '0;
	dsd_health_t health = '0;
	logic [7:0] pat = 8'hb4;
	logic [4:0] kc = '0;
	int errors = 0, num_checks = 0, n;
	initial forever #12.5 mclk = ~mclk;
	// both oscillators 200 ns, out of phase with mclk and each other
	initial begin #7; forever #100 servoClk = ~servoClk; end
	initial begin #61; forever #100 dataClk = ~dataClk; end
	// kick every 32 cycles, inside the shortened watchdog
	always @(posedge mclk) begin
		kc <= kc + 5'h01;
		watchdogKick <= kickOn && kc == 5'h00;
	end
	dsd_top #(.WD_CYCLES(50)) dut_u (.mclk(mclk), .rst(rst), .gatesIn(gatesIn), .health(health), .servoClk(servoClk),
		.dataClk(dataClk), .readBitIn(readBitIn), .echoClk(echoClk), .writeBitIn(writeBitIn), .watchdogKick(watchdogKick),
		.refClk(refClk), .readBitOut(readBitOut), .readValid(readValid), .encBit(encBit), .encStrobe(encStrobe),
		.writeEnable(writeEnable), .restoreReq(restoreReq), .driveFault(driveFault));
	dsd_ctrl_model ctrl_u (.refClk(refClk), .pat(pat), .echoClk(echoClk), .writeBit(writeBitIn), .heldBit(heldBit));
	task chk(input string name, input logic e, input logic s);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("Error %s expected %b seen %b", name, e, s);
		end
	endtask
	task go(input dsd_gates_t g, input dsd_health_t h);
		@(posedge mclk);
		gatesIn <= g;
		health <= h;
		n = 0;
	endtask
	// clear a latched fault: reset pulse while sequenced down, sector mark ends index window
	task clr;
		go(4'h8, 11'h001);
		repeat (2) @(posedge mclk);
		go(4'hc, 11'h001);
		repeat (5) @(posedge mclk);
		go(4'h8, 11'h000);
		repeat (3) @(posedge mclk);
	endtask
	task report_and_stop;
		if (errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		chk("outputs at reset", 1'b0, driveFault | writeEnable | readValid | encStrobe | restoreReq | refClk);
		foreach (rows[i]) begin
			go(rows[i].g, rows[i].h);
			repeat (6) @(negedge mclk);
			chk("fault table", rows[i].f, driveFault);
			clr();
		end
		kickOn <= 1'b0;
		repeat (70) @(negedge mclk);
		chk("watchdog fault", 1'b1, driveFault);
		kickOn <= 1'b1;
		repeat (40) @(posedge mclk);
		clr();
		go(4'hc, 11'h004);
		repeat (12) @(negedge mclk) n += restoreReq;
		chk("restore pulse", 1'b1, n == 1);
		chk("reset while up", 1'b1, driveFault);
		clr();
		go(4'h2, 11'h500);
		repeat (40) @(negedge mclk) n += encStrobe;
		chk("unselected strobes", 1'b0, n != 0);
		clr();
		go(4'ha, 11'h500);
		repeat (100) begin @(negedge mclk); if (encStrobe) begin n++; chk("write bit", heldBit, encBit); end end
		chk("write strobes", 1'b1, n > 8);
		chk("write enable", 1'b1, writeEnable);
		pat <= 8'h00;
		repeat (400) @(negedge mclk);
		chk("flux seen", 1'b0, driveFault);
		repeat (320) @(negedge mclk);
		chk("no flux fault", 1'b1, driveFault);
		chk("write enable off", 1'b0, writeEnable);
		pat <= 8'hb4;
		clr();
		// gate opens over a run of zeros, recorded ones follow later
		go(4'h9, 11'h100);
		readBitIn <= 1'b0;
		repeat (200) @(negedge mclk);
		chk("early valid", 1'b0, readValid);
		@(posedge mclk);
		readBitIn <= 1'b1;
		repeat (200) @(negedge mclk);
		chk("late valid", 1'b1, readValid & readBitOut);
		go(4'h8, 11'h100);
		repeat (5) @(negedge mclk);
		chk("gate dropped", 1'b0, readValid | readBitOut);
		report_and_stop();
	end
endmodule
